// ===== rwc_reset_watchdog.sv
`timescale 1ns/1ps
// Summary of operation
// - After any reset, instruction fetch starts at address 3FFD, which holds a jump.
// - During reset, system_options_reg and the watchdog counter take initial values, the interrupt mask keeps its value; peripherals off, pins high-impedance.
// - Seven reset sources; all but the debugger-forced one have a cause flag.
// - External reset line counts only while reset_line_enable is set.
// - reset_cause_reg shows the source of the most recent reset.
// - Enabled watchdog resets the system when reaching its count unrefreshed.
// - watchdog_enable comes up set after every reset.
// - Clearing watchdog_enable stops counting and watchdog resets.
// - Any write to reset_cause_reg clears the watchdog counter, contents unchanged.
// - watchdog_timeout_select 0 gives 32 ticks, 1 gives 256 ticks.
// - Watchdog counts the separate 1 kHz tick; long timeout after reset.
// - system_options_reg takes one write after reset, then settings are locked.
// - The first system_options_reg write also clears the watchdog counter.
// - In background debug mode the watchdog counter holds.
// - Stop mode zeroes the watchdog counter; counting restarts from zero on exit.
// - Without low voltage, a debugger-forced reset clears every cause flag.
// - Low voltage sets its flag alone; other resets set flags of active sources and clear the rest.
// - Power-up reset sets both power-up and low-voltage flags.
module rwc_reset_watchdog
    import rwc_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output wire logic               s_axi_awready,
    input  wire logic [DATA_W-1:0]  s_axi_wdata,
    input  wire logic [STRB_W-1:0]  s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output wire logic               s_axi_wready,
    output wire logic [1:0]         s_axi_bresp,
    output wire logic               s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output wire logic               s_axi_arready,
    output wire logic [DATA_W-1:0]  s_axi_rdata,
    output wire logic [1:0]         s_axi_rresp,
    output wire logic               s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               reset_pin_n,
    input  wire logic               low_voltage_detect,
    input  wire logic               tick_1khz,
    input  wire logic               illegal_opcode,
    input  wire logic               illegal_address,
    input  wire logic               debugger_forced_reset,
    input  wire logic               debug_mode,
    input  wire logic               stop_mode,
    output wire logic               sys_reset,
    output wire logic               periph_disable,
    output wire logic               io_pins_hiz,
    output wire logic               fetch_start,
    output wire logic [FETCH_W-1:0] fetch_addr,
    output wire logic               irq
);

    // Power-up leaves the system held in reset with the power-up cause
    localparam rwc_state_t RST_STATE = '{
        phase:   RWC_HOLD,
        cause:   CAUSE_POR_VAL,
        wd_en:   WD_EN_RST,
        wd_sel:  WD_SEL_RST,
        pin_en:  PIN_EN_RST,
        default: '0
    };

    rwc_state_t s;
    rwc_state_t next_s;

    logic pin_n_q;
    logic lvd_q;
    logic tick_q;

    // Pin and analog levels come from outside the clock domain
    rwc_sync #(
        .WIDTH   (3),
        .RST_VAL (3'h4)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({reset_pin_n, low_voltage_detect, tick_1khz}),
        .q       ({pin_n_q, lvd_q, tick_q})
    );

    logic              in_run;
    logic              tick_rise;
    logic              wd_step;
    logic [WD_W-1:0]   wd_last;
    logic              wd_timeout;
    logic              pin_reset;
    logic              any_source;
    logic              wr_fire;
    logic              wr_mapped;
    logic              wr_cause;
    logic              wr_opt;
    logic              wr_stat;
    logic              wr_mask;
    logic [DATA_W-1:0] rd_mux;
    logic              rd_mapped;

    assign in_run     = (s.phase == RWC_RUN);
    assign tick_rise  = tick_q & ~s.tick_d;
    assign wd_step    = in_run && s.wd_en && tick_rise && !debug_mode && !stop_mode;
    assign wd_last    = s.wd_sel ? WD_LONG_LAST : WD_SHORT_LAST;
    assign wd_timeout = wd_step && (s.wd_cnt == wd_last);
    assign pin_reset  = !pin_n_q && s.pin_en;
    assign any_source = lvd_q | pin_reset | wd_timeout | illegal_opcode
                      | illegal_address | debugger_forced_reset;

    assign wr_fire   = s.aw_held && s.w_held && !s.bvalid;
    assign wr_mapped = (s.awaddr < ADDR_MAP_END);
    assign wr_cause  = wr_fire && (s.awaddr[ADDR_W-1:2] == ADDR_CAUSE[ADDR_W-1:2]);
    assign wr_opt    = wr_fire && (s.awaddr[ADDR_W-1:2] == ADDR_OPTIONS[ADDR_W-1:2])
                     && s.wstrb[0] && !s.opt_locked;
    assign wr_stat   = wr_fire && (s.awaddr[ADDR_W-1:2] == ADDR_IRQ_STATUS[ADDR_W-1:2])
                     && s.wstrb[0];
    assign wr_mask   = wr_fire && (s.awaddr[ADDR_W-1:2] == ADDR_IRQ_MASK[ADDR_W-1:2])
                     && s.wstrb[0];
    assign rd_mapped = (s_axi_araddr < ADDR_MAP_END);

    always_comb begin
        rd_mux = '0;
        unique case (s_axi_araddr[ADDR_W-1:2])
            ADDR_CAUSE[ADDR_W-1:2]: begin
                rd_mux[CAUSE_W-1:0] = s.cause;
            end
            ADDR_OPTIONS[ADDR_W-1:2]: begin
                rd_mux[OPT_WD_EN_BIT]  = s.wd_en;
                rd_mux[OPT_WD_SEL_BIT] = s.wd_sel;
                rd_mux[OPT_LOCK_BIT]   = s.opt_locked;
                rd_mux[OPT_PIN_EN_BIT] = s.pin_en;
            end
            ADDR_IRQ_STATUS[ADDR_W-1:2]: begin
                rd_mux[IRQ_W-1:0] = s.irq_stat;
            end
            ADDR_IRQ_MASK[ADDR_W-1:2]: begin
                rd_mux[IRQ_W-1:0] = s.irq_mask;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_comb begin
        logic [IRQ_W-1:0] irq_ev;
        logic [IRQ_W-1:0] irq_clr;
        irq_ev  = '0;
        irq_clr = '0;
        next_s  = s;
        next_s.fetch_start = 1'b0;
        next_s.tick_d      = tick_q;

        // Read channel: one read at a time, answered the cycle after acceptance
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_mux;
            next_s.rresp  = rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end

        // Write channels are taken in either order and acted on once both are held
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata  = s_axi_wdata;
            next_s.wstrb  = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end

        // Watchdog counter
        if (stop_mode) begin
            next_s.wd_cnt = '0;
        end else if (wd_step) begin
            next_s.wd_cnt = s.wd_cnt + WD_ONE;
        end
        if (wr_cause || wr_opt) begin
            next_s.wd_cnt = '0;
        end
        if (wr_opt) begin
            next_s.wd_en      = s.wdata[OPT_WD_EN_BIT];
            next_s.wd_sel     = s.wdata[OPT_WD_SEL_BIT];
            next_s.pin_en     = s.wdata[OPT_PIN_EN_BIT];
            next_s.opt_locked = 1'b1;
        end
        if (wr_mask) begin
            next_s.irq_mask = s.wdata[IRQ_W-1:0];
        end
        if (wr_stat) begin
            irq_clr = s.wdata[IRQ_W-1:0];
        end
        irq_ev[IRQ_WD_BIT] = wd_timeout;

        // Reset sequencing
        unique case (s.phase)
            RWC_RUN: begin
                if (any_source) begin
                    next_s.phase    = RWC_HOLD;
                    next_s.hold_cnt = '0;
                    if (lvd_q) begin
                        next_s.cause = CAUSE_LVD_VAL;
                    end else if (debugger_forced_reset) begin
                        next_s.cause = '0;
                    end else begin
                        next_s.cause                 = '0;
                        next_s.cause[CAUSE_PIN_BIT]  = pin_reset;
                        next_s.cause[CAUSE_WD_BIT]   = wd_timeout;
                        next_s.cause[CAUSE_ILLEGAL_OPCODE_RESET_FLAG_BIT] = illegal_opcode;
                        next_s.cause[CAUSE_ILLEGAL_ADDRESS_RESET_FLAG_BIT] = illegal_address;
                    end
                end
            end
            RWC_HOLD: begin
                // A low supply keeps the system in reset past the least hold time
                if (s.hold_cnt == HOLD_LAST) begin
                    if (!lvd_q) begin
                        next_s.phase       = RWC_RUN;
                        next_s.fetch_start = 1'b1;
                        irq_ev[IRQ_RST_BIT] = 1'b1;
                    end
                end else begin
                    next_s.hold_cnt = s.hold_cnt + HOLD_ONE;
                end
            end
        endcase

        // Options return to defaults and unlock throughout reset
        if (next_s.phase == RWC_HOLD) begin
            next_s.wd_en      = WD_EN_RST;
            next_s.wd_sel     = WD_SEL_RST;
            next_s.pin_en     = PIN_EN_RST;
            next_s.opt_locked = 1'b0;
            next_s.wd_cnt     = '0;
        end

        // A new event wins over a clear in the same cycle
        next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_ev;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready  = !s.aw_held && !s.bvalid;
    assign s_axi_wready   = !s.w_held && !s.bvalid;
    assign s_axi_bvalid   = s.bvalid;
    assign s_axi_bresp    = s.bresp;
    assign s_axi_arready  = !s.rvalid;
    assign s_axi_rvalid   = s.rvalid;
    assign s_axi_rdata    = s.rdata;
    assign s_axi_rresp    = s.rresp;
    assign sys_reset      = (s.phase == RWC_HOLD);
    assign periph_disable = sys_reset;
    assign io_pins_hiz    = sys_reset;
    assign fetch_start    = s.fetch_start;
    assign fetch_addr     = FETCH_VECTOR;
    assign irq            = |(s.irq_stat & s.irq_mask);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_fetch_vector;
        fetch_start |-> fetch_addr == FETCH_VECTOR && $past(sys_reset) && !sys_reset;
    endproperty
    a_fetch_vector: assert property (p_fetch_vector) else $error("bad fetch start");

    property p_reset_defaults;
        sys_reset |-> periph_disable && io_pins_hiz && s.wd_cnt == '0 && !s.opt_locked;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset state");

    property p_por_cause;
        !$past(aresetn) |-> s.cause == CAUSE_POR_VAL && sys_reset;
    endproperty
    a_por_cause: assert property (p_por_cause) else $error("power-up cause wrong");

    property p_debugger_clears;
        in_run && debugger_forced_reset && !lvd_q |=> sys_reset && s.cause == '0;
    endproperty
    a_debugger_clears: assert property (p_debugger_clears) else $error("debug cause");

    property p_pin_gated;
        in_run && !s.pin_en && !lvd_q && !wd_timeout && !illegal_opcode
            && !illegal_address && !debugger_forced_reset |=> !sys_reset;
    endproperty
    a_pin_gated: assert property (p_pin_gated) else $error("pin reset not gated");

    property p_wd_timeout;
        wd_timeout && !lvd_q && !debugger_forced_reset
            |-> s.wd_cnt == (s.wd_sel ? WD_LONG_LAST : WD_SHORT_LAST) && s.wd_en
            ##1 sys_reset && s.cause[CAUSE_WD_BIT] && s.irq_stat[IRQ_WD_BIT];
    endproperty
    a_wd_timeout: assert property (p_wd_timeout) else $error("watchdog timeout");

    property p_wd_defaults;
        $fell(sys_reset) |-> s.wd_en && s.wd_sel && !s.opt_locked;
    endproperty
    a_wd_defaults: assert property (p_wd_defaults) else $error("option defaults");

    property p_wd_disabled;
        in_run && !s.wd_en && !wr_opt |=> s.wd_cnt == '0 || $stable(s.wd_cnt);
    endproperty
    a_wd_disabled: assert property (p_wd_disabled) else $error("disabled counts");

    property p_refresh;
        wr_cause && !(in_run && any_source) |=> s.wd_cnt == '0 && $stable(s.cause);
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh failed");

    property p_lock;
        in_run && s.opt_locked && !any_source
            |=> $stable(s.wd_en) && $stable(s.wd_sel) && $stable(s.pin_en);
    endproperty
    a_lock: assert property (p_lock) else $error("options not locked");

    property p_debug_hold;
        in_run && debug_mode && !stop_mode && !wr_cause && !wr_opt && !any_source
            |=> $stable(s.wd_cnt);
    endproperty
    a_debug_hold: assert property (p_debug_hold) else $error("counted in debug");

    property p_stop_zero;
        stop_mode |=> s.wd_cnt == '0;
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("stop not zeroing");

    c_wd_reset: cover property (wd_timeout ##1 sys_reset);
    c_refresh: cover property (s.wd_cnt != '0 ##1 wr_cause);
    c_locked: cover property (wr_opt ##1 s.opt_locked);
    c_irq: cover property ($rose(irq));

endmodule

// ===== rwc_pkg.sv
package rwc_pkg;

    // Bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CAUSE      = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_OPTIONS    = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_MAP_END    = 5'h10;

    // reset_cause_reg fields
    localparam int CAUSE_W        = 8;
    localparam int CAUSE_POR_BIT  = 7;
    localparam int CAUSE_PIN_BIT  = 6;
    localparam int CAUSE_WD_BIT   = 5;
    localparam int CAUSE_ILLEGAL_OPCODE_RESET_FLAG_BIT = 4;
    localparam int CAUSE_ILLEGAL_ADDRESS_RESET_FLAG_BIT = 3;
    localparam int CAUSE_LVD_BIT  = 1;
    localparam logic [CAUSE_W-1:0] CAUSE_POR_VAL = 8'h82;
    localparam logic [CAUSE_W-1:0] CAUSE_LVD_VAL = 8'h02;

    // system_options_reg fields and values taken at every reset
    localparam int OPT_WD_EN_BIT  = 7;
    localparam int OPT_WD_SEL_BIT = 6;
    localparam int OPT_LOCK_BIT   = 1;
    localparam int OPT_PIN_EN_BIT = 0;
    localparam logic WD_EN_RST  = 1'b1;
    localparam logic WD_SEL_RST = 1'b1;
    localparam logic PIN_EN_RST = 1'b0;

    // Interrupt status and mask layout
    localparam int IRQ_W       = 2;
    localparam int IRQ_WD_BIT  = 0;
    localparam int IRQ_RST_BIT = 1;

    // Watchdog counts, in 1 kHz ticks
    localparam int WD_W = 9;
    localparam logic [WD_W-1:0] WD_SHORT_COUNT = 9'h020;
    localparam logic [WD_W-1:0] WD_LONG_COUNT  = 9'h100;
    localparam logic [WD_W-1:0] WD_ONE         = 9'h001;
    localparam logic [WD_W-1:0] WD_SHORT_LAST  = WD_SHORT_COUNT - WD_ONE;
    localparam logic [WD_W-1:0] WD_LONG_LAST   = WD_LONG_COUNT - WD_ONE;

    // Fetch vector after any reset
    localparam int FETCH_W = 14;
    localparam logic [FETCH_W-1:0] FETCH_VECTOR = 14'h3FFD;

    // Least time the system reset stands
    localparam int CLK_PERIOD_NS     = 10;
    localparam int RESET_HOLD_NS     = 160;
    localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W            = 5;
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYCLES - 1);
    localparam logic [HOLD_W-1:0] HOLD_ONE  = 5'h01;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RWC_RUN  = 2'b01,
        RWC_HOLD = 2'b10
    } rwc_phase_t;

    typedef struct packed {
        rwc_phase_t          phase;
        logic [HOLD_W-1:0]   hold_cnt;
        logic [CAUSE_W-1:0]  cause;
        logic                wd_en;
        logic                wd_sel;
        logic                pin_en;
        logic                opt_locked;
        logic [WD_W-1:0]     wd_cnt;
        logic                tick_d;
        logic [IRQ_W-1:0]    irq_stat;
        logic [IRQ_W-1:0]    irq_mask;
        logic                aw_held;
        logic                w_held;
        logic [ADDR_W-1:0]   awaddr;
        logic [DATA_W-1:0]   wdata;
        logic [STRB_W-1:0]   wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [DATA_W-1:0]   rdata;
        logic [1:0]          rresp;
        logic                fetch_start;
    } rwc_state_t;

endpackage

// ===== rwc_sync.sv
`timescale 1ns/1ps
module rwc_sync
    import rwc_pkg::*;
#(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] d,
    output wire logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } rwc_sync_state_t;

    rwc_sync_state_t s;
    rwc_sync_state_t next_s;

    always_comb begin
        next_s.meta   = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= {RST_VAL, RST_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stable;

endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import rwc_pkg::*;
    localparam logic [31:0] OPT_DEF = {24'h00_0000, WD_EN_RST, WD_SEL_RST, 6'h00};
    // Source masks {lvd, dbg, wd, illegal_address_reset_flag, illegal_opcode_reset_flag, pin}; 6'h12 and 6'h30 are priority corners
    localparam logic [5:0]  SRC [7] = '{6'h02, 6'h04, 6'h06, 6'h10, 6'h12, 6'h20, 6'h30};
    logic               aclk = '0;
    logic               aresetn = '0;
    logic [ADDR_W-1:0]  awaddr = '0, araddr = '0;
    logic [DATA_W-1:0]  wdata = '0, rdata;
    logic [STRB_W-1:0]  wstrb = '0;
    logic               awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [1:0]         bresp, rresp, resp;
    logic               pin_n = '1, low_voltage_reset_flag = '0, tick = '0, illegal_opcode_reset_flag = '0, illegal_address_reset_flag = '0, dbg = '0;
    logic               dbg_mode = '0, stop = '0, tick_run = '0, found;
    logic               sys_reset, periph_disable, io_pins_hiz, fetch_start, irq;
    logic [FETCH_W-1:0] fetch_addr;
    logic [1:0]         tdiv = '0;
    logic [31:0]        rnd = 32'h7829_4e18, rd;
    int                 fails = 0, tests_run = 0, hold;

    rwc_reset_watchdog dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .reset_pin_n(pin_n), .low_voltage_detect(low_voltage_reset_flag), .tick_1khz(tick),
        .illegal_opcode(illegal_opcode_reset_flag), .illegal_address(illegal_address_reset_flag), .debugger_forced_reset(dbg),
        .debug_mode(dbg_mode), .stop_mode(stop), .sys_reset(sys_reset),
        .periph_disable(periph_disable), .io_pins_hiz(io_pins_hiz),
        .fetch_start(fetch_start), .fetch_addr(fetch_addr), .irq(irq)
    );

    always #5 aclk = ~aclk;

    // Slow tick, 8 bus cycles per period, so timeouts stay short in simulation
    always @(posedge aclk) begin
        if (tick_run) begin
            tdiv <= tdiv + 2'h1;
            if (tdiv == 2'h3) tick <= ~tick;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] cause_of(input logic [5:0] m);
        logic [31:0] c;
        c = '0;
        if (m[5]) begin
            c[CAUSE_LVD_BIT] = 1'b1;
        end else if (!m[4]) begin
            c[CAUSE_PIN_BIT]  = m[0];
            c[CAUSE_ILLEGAL_OPCODE_RESET_FLAG_BIT] = m[1];
            c[CAUSE_ILLEGAL_ADDRESS_RESET_FLAG_BIT] = m[2];
            c[CAUSE_WD_BIT]   = m[3];
        end
        return c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                          input logic [3:0] s = 4'hF);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [ADDR_W-1:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic src(input logic [5:0] m);
        @(posedge aclk);
        low_voltage_reset_flag <= m[5];
        // Low voltage is synchronised, so same-clock sources wait for it to meet at entry
        if (m[5]) repeat (2) @(posedge aclk);
        {dbg, illegal_address_reset_flag, illegal_opcode_reset_flag, pin_n} <= {m[4], m[2], m[1], ~m[0]};
    endtask

    // Sources are dropped once the hold has begun; the hold ignores all but low voltage, which extends it
    task automatic wait_reset(input int limit, input int exp_hold);
        found = 1'b0;
        hold = 0;
        repeat (limit) begin
            @(posedge aclk);
            #1;
            if (sys_reset === 1'b1) begin
                found = 1'b1;
                break;
            end
        end
        if (found) begin
            chk(periph_disable & io_pins_hiz, 1, "pins released in reset");
            while (sys_reset === 1'b1 && hold < 300) begin
                @(posedge aclk);
                {low_voltage_reset_flag, dbg, illegal_address_reset_flag, illegal_opcode_reset_flag, pin_n} <= 5'h01;
                #1;
                hold++;
            end
            chk(fetch_start, 1, "fetch start");
            chk(fetch_addr, FETCH_VECTOR, "fetch address");
            if (exp_hold >= 0) chk(hold, exp_hold, "hold length");
        end
    endtask

    task automatic wd_check(input int lo, input int hi);
        wait_reset(lo, -1);
        chk(found, 0, "early timeout");
        wait_reset(hi, RESET_HOLD_CYCLES);
        chk(found, 1, "timeout reset");
        axi_rd(ADDR_CAUSE);
        chk(rd, cause_of(6'h08), "watchdog cause");
        axi_rd(ADDR_OPTIONS);
        chk(rd, OPT_DEF, "options after reset");
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        $display("ERROR t=%0t run did not finish", $time);
        final_report;
    end

    initial begin
        repeat (6) @(posedge aclk);
        chk(sys_reset & periph_disable & io_pins_hiz, 1, "held in reset");
        aresetn <= 1'b1;
        tick_run <= 1'b1;
        wait_reset(5, -1);
        axi_rd(ADDR_CAUSE);
        chk(rd, CAUSE_POR_VAL, "power-up cause");
        axi_rd(ADDR_OPTIONS);
        chk(rd, OPT_DEF, "option defaults");
        axi_rd(ADDR_MAP_END);
        chk(resp, RESP_SLVERR, "unmapped read");
        axi_wr(ADDR_MAP_END, '1);
        chk(resp, RESP_SLVERR, "unmapped write");
        src(6'h01);
        wait_reset(40, -1);
        chk(found, 0, "pin while disabled");
        @(posedge aclk);
        pin_n <= 1'b1;
        axi_wr(ADDR_OPTIONS, 32'h0000_0081);
        axi_wr(ADDR_OPTIONS, 32'h0000_0000);
        axi_rd(ADDR_OPTIONS);
        chk(rd, 32'h0000_0083, "options locked");
        wd_check(230, 40);
        axi_rd(ADDR_IRQ_STATUS);
        chk(rd, 32'h0000_0003, "irq status");
        chk(irq, 0, "irq masked");
        axi_wr(ADDR_IRQ_MASK, 32'h0000_0001);
        chk(irq, 1, "irq unmasked");
        axi_wr(ADDR_IRQ_STATUS, 32'h0000_0001);
        chk(irq, 0, "irq cleared");
        axi_wr(ADDR_IRQ_MASK, 32'h0000_0003);
        chk(irq, 1, "irq second source");
        axi_wr(ADDR_IRQ_STATUS, 32'h0000_0002);
        chk(irq, 0, "irq second cleared");
        rnd = lfsr(rnd);
        repeat (200 + int'(rnd[4:0])) @(posedge aclk);
        axi_wr(ADDR_CAUSE, rnd, rnd[3:0]);
        axi_rd(ADDR_CAUSE);
        chk(rd, cause_of(6'h08), "cause after refresh");
        wd_check(2000, 80);
        axi_wr(ADDR_OPTIONS, 32'h0000_0080);
        repeat (120) @(posedge aclk);
        dbg_mode <= 1'b1;
        wait_reset(400, -1);
        chk(found, 0, "frozen in debug");
        @(posedge aclk);
        dbg_mode <= 1'b0;
        stop <= 1'b1;
        wait_reset(400, -1);
        chk(found, 0, "cleared in stop");
        @(posedge aclk);
        stop <= 1'b0;
        wd_check(240, 40);
        axi_wr(ADDR_OPTIONS, 32'h0000_0040);
        wait_reset(2200, -1);
        chk(found, 0, "watchdog disabled");
        foreach (SRC[i]) begin
            rnd = lfsr(rnd);
            repeat (int'(rnd[3:0])) @(posedge aclk);
            src(SRC[i]);
            wait_reset(20, SRC[i][5] ? -1 : RESET_HOLD_CYCLES);
            axi_rd(ADDR_CAUSE);
            chk(rd, cause_of(SRC[i]), "source cause");
        end
        axi_wr(ADDR_OPTIONS, 32'h0000_0000, 4'hE);
        axi_wr(ADDR_OPTIONS, 32'h0000_0041);
        src(6'h01);
        wait_reset(20, RESET_HOLD_CYCLES);
        axi_rd(ADDR_CAUSE);
        chk(rd, cause_of(6'h01), "pin cause");
        final_report;
    end
endmodule
